// *** rtl/alc_gain_ramp_pkg.sv ***
package alc_gain_ramp_pkg;

	typedef enum logic [1:0] {
		ST_OFF = 2'b01,
		ST_ON = 2'b10
	} alc_state_t;

	localparam int TIMER_W = 34;
	localparam int CLK_MHZ = 200;

	// per-step times at the base code, in ns
	localparam int ATK_NORM_NS = 104000;
	localparam int ATK_LIM_NS = 22700;
	localparam int DCY_NORM_NS = 410000;
	localparam int DCY_LIM_NS = 90800;
	localparam int HOLD_BASE_NS = 2670000;

	localparam logic [TIMER_W-1:0] ATK_NORM_CYC = TIMER_W'(ATK_NORM_NS * CLK_MHZ / 1000);
	localparam logic [TIMER_W-1:0] ATK_LIM_CYC = TIMER_W'(ATK_LIM_NS * CLK_MHZ / 1000);
	localparam logic [TIMER_W-1:0] DCY_NORM_CYC = TIMER_W'(DCY_NORM_NS * CLK_MHZ / 1000);
	localparam logic [TIMER_W-1:0] DCY_LIM_CYC = TIMER_W'(DCY_LIM_NS * CLK_MHZ / 1000);
	localparam logic [TIMER_W-1:0] HOLD_BASE_CYC = TIMER_W'(HOLD_BASE_NS * CLK_MHZ / 1000);

	// rate codes saturate here; hold code n doubles from code 1
	localparam logic [3:0] CODE_SAT = 4'ha;
	localparam logic [3:0] HOLD_SHIFT_MAX = 4'h9;

	// sample-rate scale in sixteenths
	localparam logic [4:0] SR_SCALE [0:7] = '{5'h10, 5'h11, 5'h10, 5'h11,
		5'h10, 5'h11, 5'h10, 5'h10};

	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_RATE = 6'h07;
	localparam logic [5:0] IDX_ENABLE = 6'h20;
	localparam logic [5:0] IDX_TARGET = 6'h21;
	localparam logic [5:0] IDX_MODE = 6'h22;
	localparam logic [5:0] IDX_HOLD = 6'h23;
	localparam logic [5:0] IDX_ZC = 6'h2a;
	localparam logic [5:0] IDX_GAIN = 6'h2d;

	localparam int EN_BIT = 8;
	localparam int TARGET_LSB = 0;
	localparam int MODE_BIT = 8;
	localparam int RISE_LSB = 4;
	localparam int FALL_LSB = 0;
	localparam int HOLD_LSB = 4;
	localparam int ZC_BIT = 1;
	localparam int GAIN_LSB = 0;
	localparam int SILENCE_BIT = 6;
	localparam int RATE_LSB = 0;

	localparam logic [3:0] TARGET_RST = 4'hb;
	localparam logic [3:0] RISE_RST = 4'h3;
	localparam logic [3:0] FALL_RST = 4'h2;
	localparam logic [3:0] HOLD_RST = 4'h0;
	localparam logic [5:0] GAIN_RST = 6'h10;
	localparam logic [5:0] GAIN_MAX = 6'h3f;
	localparam logic [2:0] RATE_RST = 3'h0;

endpackage

// *** rtl/alc_pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module alc_pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic [WIDTH-1:0] pin_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] stage1;

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			stage1 <= '0;
			sync_o <= '0;
		end else begin
			stage1 <= pin_i;
			sync_o <= stage1;
		end
	end
endmodule // alc_pin_sync
`default_nettype wire

// *** rtl/alc_interval_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module alc_interval_timer #(
	parameter int WIDTH = 34
) (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic clear_i,
	input wire logic [WIDTH-1:0] limit_i,
	output logic done_o
);
	logic [WIDTH-1:0] count;

	// stops at the limit so a gated step can wait for a zero crossing
	assign done_o = count >= limit_i;

	always_ff @(posedge clock_i) begin
		if (!resetn_i || clear_i) begin
			count <= '0;
		end else if (!done_o) begin
			count <= count + WIDTH'(1);
		end
	end
endmodule // alc_interval_timer
`default_nettype wire

// *** rtl/alc_gain_ramp_control.sv ***
// Functional notes
// - automatic gain control acts only while the enable bit is set, otherwise it leaves gain alone.
// - peak above target lowers gain at the attack rate, peak below target raises it at decay rate.
// - one mode bit selects normal level control or peak limiting.
// - attack step interval doubles per four-bit code from a mode-dependent base and saturates.
// - decay step interval doubles per four-bit code from a mode-dependent base and saturates.
// - attack timing governs every gain decrease and decay timing every gain increase.
// - limiter mode uses faster intervals than normal mode for the same code.
// - step intervals scale with the selected sample-rate setting.
// - normal mode keeps raising or lowering gain to hold the level at the target.
// - limiter mode cuts gain on peaks and never raises it above the captured start level.
// - starting directly in limiter mode captures the gain at start-up as the ceiling.
// - switching from normal to limiter while running captures the gain at switchover.
// - when disabled the gain freezes and changes only on a software write of the gain field.
// - with the zero-cross gate set steps wait for a zero crossing, otherwise apply at once.
`timescale 1ns/1ps
`default_nettype none
module alc_gain_ramp_control #(
	parameter int ADDR_W = 8,
	parameter logic [alc_gain_ramp_pkg::TIMER_W-1:0] ATK_NORM_CYC = alc_gain_ramp_pkg::ATK_NORM_CYC,
	parameter logic [alc_gain_ramp_pkg::TIMER_W-1:0] ATK_LIM_CYC = alc_gain_ramp_pkg::ATK_LIM_CYC,
	parameter logic [alc_gain_ramp_pkg::TIMER_W-1:0] DCY_NORM_CYC = alc_gain_ramp_pkg::DCY_NORM_CYC,
	parameter logic [alc_gain_ramp_pkg::TIMER_W-1:0] DCY_LIM_CYC = alc_gain_ramp_pkg::DCY_LIM_CYC,
	parameter logic [alc_gain_ramp_pkg::TIMER_W-1:0] HOLD_BASE_CYC = alc_gain_ramp_pkg::HOLD_BASE_CYC
) (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic [3:0] peak_code_i,
	input wire logic zero_cross_i,
	output logic [5:0] input_amp_gain_o,
	output logic input_amp_silence_o
);
	localparam int TW = alc_gain_ramp_pkg::TIMER_W;

	alc_gain_ramp_pkg::alc_state_t state;
	logic level_ctrl_enable;
	logic [3:0] target_level_code;
	logic limiter_select;
	logic [3:0] gain_rise_rate_code;
	logic [3:0] gain_fall_rate_code;
	logic [3:0] gain_rise_hold_code;
	logic zero_crossing_gate;
	logic [2:0] sample_rate_select;
	logic input_amp_silence;
	logic [5:0] gain;
	logic [5:0] ceiling;
	logic limiter_q;
	logic [1:0] dir_q;
	logic [TW-1:0] gap_cnt;
	logic [TW-1:0] below_cnt;
	logic [3:0] peak_s;
	logic zc_s;

	alc_pin_sync #(.WIDTH(5)) u_sync (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.pin_i({zero_cross_i, peak_code_i}),
		.sync_o({zc_s, peak_s})
	);

	// apb decode
	wire [5:0] reg_idx = paddr_i[7:2];
	wire setup = psel_i && !penable_i;
	wire wr_en = psel_i && penable_i && pwrite_i;
	wire hit_rate = reg_idx == alc_gain_ramp_pkg::IDX_RATE;
	wire hit_enable = reg_idx == alc_gain_ramp_pkg::IDX_ENABLE;
	wire hit_target = reg_idx == alc_gain_ramp_pkg::IDX_TARGET;
	wire hit_mode = reg_idx == alc_gain_ramp_pkg::IDX_MODE;
	wire hit_hold = reg_idx == alc_gain_ramp_pkg::IDX_HOLD;
	wire hit_zc = reg_idx == alc_gain_ramp_pkg::IDX_ZC;
	wire hit_gain = reg_idx == alc_gain_ramp_pkg::IDX_GAIN;
	wire mapped = hit_rate | hit_enable | hit_target | hit_mode | hit_hold | hit_zc | hit_gain;

	wire [31:0] rd_rate = 32'(sample_rate_select) << alc_gain_ramp_pkg::RATE_LSB;
	wire [31:0] rd_enable = 32'(level_ctrl_enable) << alc_gain_ramp_pkg::EN_BIT;
	wire [31:0] rd_target = 32'(target_level_code) << alc_gain_ramp_pkg::TARGET_LSB;
	wire [31:0] rd_mode = (32'(limiter_select) << alc_gain_ramp_pkg::MODE_BIT)
		| (32'(gain_rise_rate_code) << alc_gain_ramp_pkg::RISE_LSB)
		| (32'(gain_fall_rate_code) << alc_gain_ramp_pkg::FALL_LSB);
	wire [31:0] rd_hold = 32'(gain_rise_hold_code) << alc_gain_ramp_pkg::HOLD_LSB;
	wire [31:0] rd_zc = 32'(zero_crossing_gate) << alc_gain_ramp_pkg::ZC_BIT;
	// gain reads back the live value, also while the loop runs
	wire [31:0] rd_gain = (32'(input_amp_silence) << alc_gain_ramp_pkg::SILENCE_BIT)
		| (32'(gain) << alc_gain_ramp_pkg::GAIN_LSB);
	wire [31:0] rd_mux = hit_rate ? rd_rate :
		hit_enable ? rd_enable :
		hit_target ? rd_target :
		hit_mode ? rd_mode :
		hit_hold ? rd_hold :
		hit_zc ? rd_zc :
		hit_gain ? rd_gain : 32'h0000_0000;

	assign pready_o = 1'b1;

	// read data and error latched in the setup cycle so they come from flops
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			prdata_o <= 32'h0000_0000;
			pslverr_o <= 1'b0;
		end else if (setup) begin
			prdata_o <= rd_mux;
			pslverr_o <= !mapped;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			level_ctrl_enable <= 1'b0;
			target_level_code <= alc_gain_ramp_pkg::TARGET_RST;
			limiter_select <= 1'b0;
			gain_rise_rate_code <= alc_gain_ramp_pkg::RISE_RST;
			gain_fall_rate_code <= alc_gain_ramp_pkg::FALL_RST;
			gain_rise_hold_code <= alc_gain_ramp_pkg::HOLD_RST;
			zero_crossing_gate <= 1'b0;
			sample_rate_select <= alc_gain_ramp_pkg::RATE_RST;
			input_amp_silence <= 1'b0;
		end else if (wr_en) begin
			if (hit_enable) begin
				level_ctrl_enable <= pwdata_i[alc_gain_ramp_pkg::EN_BIT];
			end
			if (hit_target) begin
				target_level_code <= pwdata_i[alc_gain_ramp_pkg::TARGET_LSB +: 4];
			end
			if (hit_mode) begin
				limiter_select <= pwdata_i[alc_gain_ramp_pkg::MODE_BIT];
				gain_rise_rate_code <= pwdata_i[alc_gain_ramp_pkg::RISE_LSB +: 4];
				gain_fall_rate_code <= pwdata_i[alc_gain_ramp_pkg::FALL_LSB +: 4];
			end
			if (hit_hold) begin
				gain_rise_hold_code <= pwdata_i[alc_gain_ramp_pkg::HOLD_LSB +: 4];
			end
			if (hit_zc) begin
				zero_crossing_gate <= pwdata_i[alc_gain_ramp_pkg::ZC_BIT];
			end
			if (hit_rate) begin
				sample_rate_select <= pwdata_i[alc_gain_ramp_pkg::RATE_LSB +: 3];
			end
			if (hit_gain) begin
				input_amp_silence <= pwdata_i[alc_gain_ramp_pkg::SILENCE_BIT];
			end
		end
	end

	// interval selection
	wire [TW-1:0] sr_scale = TW'(alc_gain_ramp_pkg::SR_SCALE[sample_rate_select]);
	wire [TW-1:0] fall_base = limiter_select ? ATK_LIM_CYC : ATK_NORM_CYC;
	wire [TW-1:0] rise_base = limiter_select ? DCY_LIM_CYC : DCY_NORM_CYC;
	wire [TW-1:0] fall_scaled = TW'((fall_base * sr_scale) >> 4);
	wire [TW-1:0] rise_scaled = TW'((rise_base * sr_scale) >> 4);
	wire [TW-1:0] hold_scaled = TW'((HOLD_BASE_CYC * sr_scale) >> 4);
	wire [3:0] fall_sh = (gain_fall_rate_code > alc_gain_ramp_pkg::CODE_SAT) ?
		alc_gain_ramp_pkg::CODE_SAT : gain_fall_rate_code;
	wire [3:0] rise_sh = (gain_rise_rate_code > alc_gain_ramp_pkg::CODE_SAT) ?
		alc_gain_ramp_pkg::CODE_SAT : gain_rise_rate_code;
	wire [3:0] hold_sh = (gain_rise_hold_code > alc_gain_ramp_pkg::CODE_SAT) ?
		alc_gain_ramp_pkg::HOLD_SHIFT_MAX : 4'(gain_rise_hold_code - 4'h1);
	wire [TW-1:0] fall_iv = fall_scaled << fall_sh;
	wire [TW-1:0] rise_iv = rise_scaled << rise_sh;
	wire [TW-1:0] hold_iv = hold_scaled << hold_sh;

	// loop control
	wire on = state == alc_gain_ramp_pkg::ST_ON;
	wire start = (state == alc_gain_ramp_pkg::ST_OFF) && level_ctrl_enable;
	wire mode_rise = on && limiter_select && !limiter_q;
	wire capture = start || mode_rise;
	wire above = peak_s > target_level_code;
	wire below = peak_s < target_level_code;
	wire hold_tdone;
	wire hold_done = (gain_rise_hold_code == 4'h0) || hold_tdone;
	wire dir_dn = on && above;
	wire dir_up = on && below && hold_done;
	wire zc_ok = !zero_crossing_gate || zc_s;
	// normal mode may climb to the top code, limiter stops at the ceiling
	wire [5:0] top = limiter_select ? ceiling : alc_gain_ramp_pkg::GAIN_MAX;
	wire step_tdone;
	wire step_dn = dir_dn && step_tdone && zc_ok && !capture && (gain != 6'h00);
	wire step_up = dir_up && step_tdone && zc_ok && !capture && (gain < top);
	wire step_clear = !(dir_dn || dir_up) || ({dir_dn, dir_up} != dir_q) || step_dn || step_up;
	wire [TW-1:0] step_iv = dir_dn ? fall_iv : rise_iv;
	wire gain_wr_off = wr_en && hit_gain && !on;
	wire [5:0] next_gain = gain_wr_off ? pwdata_i[alc_gain_ramp_pkg::GAIN_LSB +: 6] :
		step_dn ? 6'(gain - 6'h01) :
		step_up ? 6'(gain + 6'h01) : gain;

	alc_interval_timer #(.WIDTH(TW)) u_step_timer (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.clear_i(step_clear),
		.limit_i(step_iv),
		.done_o(step_tdone)
	);

	// hold restarts whenever the level stops being below target
	alc_interval_timer #(.WIDTH(TW)) u_hold_timer (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.clear_i(!(on && below)),
		.limit_i(hold_iv),
		.done_o(hold_tdone)
	);

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			state <= alc_gain_ramp_pkg::ST_OFF;
		end else begin
			unique case (state)
				alc_gain_ramp_pkg::ST_OFF: begin
					if (level_ctrl_enable) begin
						state <= alc_gain_ramp_pkg::ST_ON;
					end
				end
				alc_gain_ramp_pkg::ST_ON: begin
					if (!level_ctrl_enable) begin
						state <= alc_gain_ramp_pkg::ST_OFF;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			gain <= alc_gain_ramp_pkg::GAIN_RST;
			ceiling <= alc_gain_ramp_pkg::GAIN_RST;
			limiter_q <= 1'b0;
			dir_q <= 2'b00;
		end else begin
			gain <= next_gain;
			limiter_q <= limiter_select;
			dir_q <= {dir_dn, dir_up};
			if (capture) begin
				ceiling <= gain;
			end
		end
	end

	assign input_amp_gain_o = gain;
	assign input_amp_silence_o = input_amp_silence;

	// cycles since the last gain step, read only by the checks below
	always_ff @(posedge clock_i) begin
		if (!resetn_i || step_dn || step_up) begin
			gap_cnt <= '0;
		end else if (gap_cnt != {TW{1'b1}}) begin
			gap_cnt <= gap_cnt + TW'(1);
		end
	end

	// cycles spent below target without a break, kept apart from the hold timer
	always_ff @(posedge clock_i) begin
		if (!resetn_i || !(on && below)) begin
			below_cnt <= '0;
		end else if (below_cnt != {TW{1'b1}}) begin
			below_cnt <= below_cnt + TW'(1);
		end
	end

	sequence s_below_starts;
		$rose(on && below) && (gain_rise_hold_code != 4'h0);
	endsequence

	sequence s_no_rise;
		!step_up [*8];
	endsequence

	sequence s_enable_seen;
		!on && level_ctrl_enable;
	endsequence

	sequence s_gain_held;
		gain == $past(gain);
	endsequence

	a_off_gain_frozen: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(!on && !(wr_en && hit_gain)) |=> gain == $past(gain))
		else $error("gain moved while the loop was off");
	a_gain_write_off: assert property (@(posedge clock_i) disable iff (!resetn_i)
		gain_wr_off |=> gain == $past(pwdata_i[5:0]))
		else $error("gain write while off not applied");
	a_fall_one_step: assert property (@(posedge clock_i) disable iff (!resetn_i)
		step_dn |=> gain == 6'($past(gain) - 6'h01))
		else $error("attack step did not lower gain by one");
	a_no_fall_unless: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(on && !above && !wr_en) |=> gain >= $past(gain))
		else $error("gain fell without a peak above target");
	a_fall_spacing: assert property (@(posedge clock_i) disable iff (!resetn_i)
		step_dn |-> gap_cnt >= fall_iv)
		else $error("gain fell sooner than the attack interval");
	a_rise_spacing: assert property (@(posedge clock_i) disable iff (!resetn_i)
		step_up |-> gap_cnt >= rise_iv)
		else $error("gain rose sooner than the decay interval");
	a_limit_ceiling: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(on && limiter_select && $past(on && limiter_select)) |-> gain <= ceiling)
		else $error("limiter raised gain above its ceiling");
	a_start_capture: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(start && limiter_select) |=> (ceiling == $past(gain)) && on)
		else $error("start-up gain not captured");
	a_switch_capture: assert property (@(posedge clock_i) disable iff (!resetn_i)
		mode_rise |=> (ceiling == $past(gain)) && (gain == $past(gain)))
		else $error("switchover gain not captured");
	a_zc_gate: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(on && zero_crossing_gate && !zc_s) |=> gain == $past(gain))
		else $error("gain stepped away from a zero crossing");
	a_hold_rise: assert property (@(posedge clock_i) disable iff (!resetn_i)
		s_below_starts |-> s_no_rise)
		else $error("gain rose inside the hold interval");

	// the span check holds even if the hold timer limit is miswired
	a_hold_span: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(step_up && (gain_rise_hold_code != 4'h0)) |-> below_cnt >= hold_iv)
		else $error("gain rose before the hold interval ran out");
	a_enable_on: assert property (@(posedge clock_i) disable iff (!resetn_i)
		s_enable_seen |=> on)
		else $error("loop did not start on enable");
	a_enable_off: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(on && !level_ctrl_enable) |=> !on)
		else $error("loop kept running after disable");
	a_rise_one_step: assert property (@(posedge clock_i) disable iff (!resetn_i)
		step_up |=> gain == 6'($past(gain) + 6'h01))
		else $error("decay step did not raise gain by one");
	a_no_rise_unless: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(on && !below && !wr_en) |=> gain <= $past(gain))
		else $error("gain rose without a level below target");
	a_write_on_ignored: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(on && wr_en && hit_gain && !step_dn && !step_up) |=> s_gain_held)
		else $error("gain write while running was applied");
	a_ceiling_steady: assert property (@(posedge clock_i) disable iff (!resetn_i)
		!capture |=> ceiling == $past(ceiling))
		else $error("limiter ceiling moved outside a capture");
	a_zc_open: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(on && !zero_crossing_gate && above && step_tdone && !capture && (gain != 6'h00))
		|=> gain == 6'($past(gain) - 6'h01))
		else $error("due step held back with the crossing gate clear");

endmodule // alc_gain_ramp_control
`default_nettype wire

// *** verif/alc_peak_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module alc_peak_model #(
	parameter int ZC_PERIOD = 7
) (
	input wire logic clock_i,
	input wire logic [3:0] level_i,
	input wire logic zc_run_i,
	output logic [3:0] peak_code_o = 4'h0,
	output logic zero_cross_o = 1'b0
);
	int count = 0;
	// detector lags the commanded level by one cycle, like a real filter
	always @(posedge clock_i) begin
		peak_code_o <= level_i;
		count <= (count == ZC_PERIOD - 1) ? 0 : count + 1;
		// crossings only when the bench says signal is present
		zero_cross_o <= zc_run_i && count == 0;
	end
endmodule // alc_peak_model
`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int LIMIT = 90000;
	logic clock_i, resetn_i, psel, penable, pwrite, pready, err, pslverr;
	logic zc_run, zero_cross, silence;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] peak, level;
	logic [5:0] gain, g0;
	logic [5:0] ridx [7] = '{6'h07, 6'h20, 6'h21, 6'h22, 6'h23, 6'h2a, 6'h2d};
	logic [31:0] rrst [7] = '{32'h0, 32'h0, 32'hb, 32'h32, 32'h0, 32'h0, 32'h10};
	int bad_count = 0;
	int tests_run = 0;
	int cyc = 0;
	int seed, t, c;

	alc_gain_ramp_control #(.ATK_NORM_CYC(34'd16), .ATK_LIM_CYC(34'd8),
		.DCY_NORM_CYC(34'd32), .DCY_LIM_CYC(34'd16), .HOLD_BASE_CYC(34'd16)
	) i_alc_gain_ramp_control (.clock_i(clock_i), .resetn_i(resetn_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .peak_code_i(peak),
		.zero_cross_i(zero_cross), .input_amp_gain_o(gain), .input_amp_silence_o(silence));
	alc_peak_model i_alc_peak_model (.clock_i(clock_i), .level_i(level), .zc_run_i(zc_run),
		.peak_code_o(peak), .zero_cross_o(zero_cross));

	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end

	task automatic complete_run;
		$display("checks %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			bad_count++;
			complete_run;
		end
	end

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] d);
		@(posedge clock_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge clock_i);
		penable <= 1'b1;
		do @(posedge clock_i); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic en(input logic on);
		apb(1'b1, 6'h20, {23'h0, on, 8'h0});
	endtask

	// gain must not move for n cycles
	task automatic idle(input int n, input string what);
		@(negedge clock_i);
		g0 = gain;
		repeat (n) @(negedge clock_i);
		check(what, g0, gain);
	endtask

	task automatic wait_step(output int n);
		logic [5:0] g;
		@(negedge clock_i);
		g = gain;
		n = 0;
		while (gain === g && n < 40000) begin
			@(negedge clock_i);
			n++;
		end
	endtask

	task automatic in_range(input string what, input int lo, input int hi);
		tests_run++;
		if (t < lo || t > hi) begin
			bad_count++;
			$display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, hi, t);
		end
	endtask

	// first step realigns the timer, second one is measured
	task automatic gap(input string what, input int exp, input logic down);
		logic [5:0] g;
		wait_step(t);
		g = gain;
		wait_step(t);
		check(what, 32'(down ? g - 6'd1 : g + 6'd1), 32'(gain));
		in_range(what, exp, exp + 2);
	endtask

	function automatic int ivl(input int base, input int code, input int scale);
		return ((base * scale) >> 4) << (code > 10 ? 10 : code);
	endfunction

	initial begin
		seed = 32'h093e1471;
		{psel, penable, pwrite, zc_run} = 4'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		level = 4'h0;
		resetn_i = 1'b0;
		repeat (16) @(posedge clock_i);
		resetn_i <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			apb(1'b0, ridx[i], 32'h0);
			check("reset value", rrst[i], rd);
		end
		apb(1'b0, 6'h3f, 32'h0);
		check("unmapped error", 32'h1, 32'(err));
		check("unmapped data", 32'h0, rd);
		apb(1'b1, 6'h2d, 32'h60);
		idle(2, "gain write");
		check("gain written", 32'h20, 32'(gain));
		check("silence set", 32'h1, 32'(silence));
		apb(1'b1, 6'h2d, 32'h20);
		idle(300, "gain off");
		c = $unsigned($random(seed)) % 3;
		apb(1'b1, 6'h22, {24'h0, c[3:0], c[3:0]});
		level <= 4'hc + 4'($unsigned($random(seed)) % 4);
		en(1'b1);
		gap("normal fall", ivl(16, c, 16), 1'b1);
		level <= 4'($unsigned($random(seed)) % 11);
		gap("normal rise", ivl(32, c, 16), 1'b0);
		level <= 4'hb;
		idle(300, "at target");
		// two steps down and two up bring the gain back to the written value
		apb(1'b1, 6'h2d, 32'h05);
		idle(2, "gain write on");
		check("gain held on", 32'h20, 32'(gain));
		g0 = gain;
		apb(1'b1, 6'h22, 32'h100);
		level <= 4'h0;
		idle(400, "limiter ceiling");
		level <= 4'hf;
		gap("limiter fall", ivl(8, 0, 16), 1'b1);
		level <= 4'h0;
		repeat (200) @(negedge clock_i);
		check("limiter recover", 32'(g0), 32'(gain));
		apb(1'b1, 6'h22, 32'h10f);
		level <= 4'hf;
		gap("attack saturate", ivl(8, 15, 16), 1'b1);
		// limiter decay keeps the run short; two steps end exactly at the ceiling
		apb(1'b1, 6'h22, 32'h1f0);
		level <= 4'h0;
		gap("decay saturate", ivl(16, 15, 16), 1'b0);
		en(1'b0);
		level <= 4'hf;
		idle(500, "frozen");
		apb(1'b1, 6'h2d, 32'h18);
		apb(1'b1, 6'h22, 32'h100);
		level <= 4'h0;
		en(1'b1);
		idle(400, "start ceiling");
		check("start gain", 32'h18, 32'(gain));
		for (int h = 0; h < 3; h++) begin
			en(1'b0);
			apb(1'b1, 6'h22, 32'h0);
			apb(1'b1, 6'h23, 32'(h) << 4);
			en(1'b1);
			wait_step(t);
			in_range("hold", h == 0 ? 0 : 16 << (h - 1), (h == 0 ? 0 : 16 << (h - 1)) + 40);
		end
		en(1'b0);
		apb(1'b1, 6'h23, 32'h0);
		apb(1'b1, 6'h07, 32'h1);
		apb(1'b1, 6'h22, 32'h2);
		level <= 4'hf;
		en(1'b1);
		gap("rate scale", ivl(16, 2, int'(alc_gain_ramp_pkg::SR_SCALE[1])), 1'b1);
		en(1'b0);
		apb(1'b1, 6'h07, 32'h0);
		apb(1'b1, 6'h2a, 32'h2);
		apb(1'b1, 6'h22, 32'h0);
		en(1'b1);
		idle(400, "no crossing");
		zc_run <= 1'b1;
		wait_step(t);
		check("step on crossing", 32'(g0 - 6'd1), 32'(gain));
		complete_run;
	end
endmodule // tb
`default_nettype wire
